// [rtl/split_timer.sv]
// Split 16-bit general timer: two identical halves behind Wishbone.
// Assumes asynchronous pins, one clock and a debugger halt level input.
//
// Overview of operation
// - Config value 0x4 selects split halves.
// - 16-bit down-counter, prescale N gives N+1.
// - Mode field picks one-shot or periodic.
// - Enable counts down, reloads after zero.
// - One-shot clears enable; periodic keeps counting.
// - Zero sets sticky timeout flag, masked copy.
// - Converter trigger only when its enable set.
// - Interval write reloads counter next cycle.
// - Stall bit freezes counting during debug halt.
// - No prescale in edge or PWM modes.
// - Capture bit clear selects edge counting.
// - Each selected edge decrements; match sets flags.
// - After match reload, clear enable, ignore edges.
// - Edge time free-runs from interval load.
// - Edge copies count to value register, flags.
// - Edge time keeps counting, reloads at zero.
// - Captured count held until next edge.
// - PWM needs alternate 1, capture 0, mode 2.
// - PWM reloads at zero, sets no flags.
// - PWM high at start, low at match, invertible.
//
// The implementer's own choices: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ns
module split_timer
  import timer_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic debug_halt,
  input wire logic [1:0] ccp_in,
  output logic [1:0] ccp_out,
  output logic [1:0] ccp_oe,
  output logic [1:0] adc_trig,
  output logic timer_irq
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic hit(input logic [ADR_W-1:0] adr,
                               input logic [ADR_W-1:0] off);
    hit = (adr[ADR_W-1:2] == off[ADR_W-1:2]);
  endfunction

  function automatic logic [15:0] lanes16(input logic [15:0] old,
                                          input logic [15:0] wd,
                                          input logic [1:0] sel);
    lanes16 = {sel[1] ? wd[15:8] : old[15:8], sel[0] ? wd[7:0] : old[7:0]};
  endfunction

  // ****************************************
  // Bus decode
  // ****************************************
  logic [2:0] cfg;
  logic [15:0] imr;
  logic [15:0] ctl_all;
  logic [15:0] ris_all;
  logic [15:0] mis_all;
  logic [1:0][3:0] mode_all;
  logic [1:0][15:0] ilr_all;
  logic [1:0][15:0] match_all;
  logic [1:0][7:0] pr_all;
  logic [1:0][15:0] val_all;
  logic [31:0] next_rd;

  wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr = req & wb_we_i;
  wire split = (cfg == CFG_SPLIT);
  wire wr_cfg = wr & hit(wb_adr_i, OFF_CFG);
  wire wr_ctl = wr & hit(wb_adr_i, OFF_CTL);
  wire wr_imr = wr & hit(wb_adr_i, OFF_IMR);
  wire wr_icr = wr & hit(wb_adr_i, OFF_ICR);
  wire [15:0] ctl_wdata = lanes16(ctl_all, wb_dat_i[15:0], wb_sel_i[1:0]);
  wire [15:0] icr_bits = wr_icr ? (wb_dat_i[15:0] & {{8{wb_sel_i[1]}},
                                   {8{wb_sel_i[0]}}}) : 16'h0000;

  assign mis_all = ris_all & imr;

  // ****************************************
  // Read selection
  // ****************************************
  always_comb begin
    next_rd = 32'h0000_0000;
    if (hit(wb_adr_i, OFF_CFG)) begin
      next_rd[2:0] = cfg;
    end else if (hit(wb_adr_i, OFF_MODE[0])) begin
      next_rd[3:0] = mode_all[0];
    end else if (hit(wb_adr_i, OFF_MODE[1])) begin
      next_rd[3:0] = mode_all[1];
    end else if (hit(wb_adr_i, OFF_CTL)) begin
      next_rd[15:0] = ctl_all;
    end else if (hit(wb_adr_i, OFF_IMR)) begin
      next_rd[15:0] = imr;
    end else if (hit(wb_adr_i, OFF_RIS)) begin
      next_rd[15:0] = ris_all;
    end else if (hit(wb_adr_i, OFF_MIS)) begin
      next_rd[15:0] = mis_all;
    end else if (hit(wb_adr_i, OFF_ILR[0])) begin
      next_rd[15:0] = ilr_all[0];
    end else if (hit(wb_adr_i, OFF_ILR[1])) begin
      next_rd[15:0] = ilr_all[1];
    end else if (hit(wb_adr_i, OFF_MATCH[0])) begin
      next_rd[15:0] = match_all[0];
    end else if (hit(wb_adr_i, OFF_MATCH[1])) begin
      next_rd[15:0] = match_all[1];
    end else if (hit(wb_adr_i, OFF_PRE[0])) begin
      next_rd[7:0] = pr_all[0];
    end else if (hit(wb_adr_i, OFF_PRE[1])) begin
      next_rd[7:0] = pr_all[1];
    end else if (hit(wb_adr_i, OFF_VAL[0])) begin
      next_rd[15:0] = val_all[0];
    end else if (hit(wb_adr_i, OFF_VAL[1])) begin
      next_rd[15:0] = val_all[1];
    end
  end

  // ****************************************
  // Bus slave and shared registers
  // ****************************************
  // Every access, mapped or not, is answered one cycle after it is seen
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      cfg <= 3'h0;
      imr <= 16'h0000;
      timer_irq <= 1'b0;
    end else if (clk_en) begin
      wb_ack_o <= req;
      if (req && !wb_we_i) begin
        wb_dat_o <= next_rd;
      end
      if (wr_cfg && wb_sel_i[0]) begin
        cfg <= wb_dat_i[2:0];
      end
      if (wr_imr) begin
        imr <= lanes16(imr, wb_dat_i[15:0], wb_sel_i[1:0]);
      end
      timer_irq <= |mis_all;
    end
  end

  // ****************************************
  // Timer halves
  // ****************************************
  for (genvar h = 0; h < 2; h++) begin : g_half
    logic [15:0] cnt;
    logic [15:0] ilr;
    logic [15:0] match;
    logic [15:0] cap;
    logic [7:0] pr;
    logic [7:0] pcnt;
    half_mode_t mode;
    half_ctl_t ctl;
    logic [FLAG_W-1:0] ris;
    logic pwm_lvl;
    logic rise;
    logic fall;
    op_t op;
    logic [15:0] next_cnt;
    logic [7:0] next_pcnt;
    logic next_pwm;
    logic hw_stop;
    logic hit_to;
    logic hit_mt;
    logic hit_ce;

    wire wr_mode = wr & hit(wb_adr_i, OFF_MODE[h]);
    wire wr_ilr = wr & hit(wb_adr_i, OFF_ILR[h]);
    wire wr_match = wr & hit(wb_adr_i, OFF_MATCH[h]);
    wire wr_pr = wr & hit(wb_adr_i, OFF_PRE[h]) & wb_sel_i[0];
    wire [15:0] ilr_new = lanes16(ilr, wb_dat_i[15:0], wb_sel_i[1:0]);
    wire run = ctl.en & ~(ctl.stall & debug_halt);
    wire at_zero = (cnt == CNT_ZERO);
    wire [15:0] cnt_dec = cnt - CNT_ONE;
    wire ev = (ctl.event_sel == EV_RISE && rise) ||
              (ctl.event_sel == EV_FALL && fall) ||
              (ctl.event_sel == EV_BOTH && (rise || fall));
    wire [FLAG_W-1:0] flag_set = {hit_ce, hit_mt, hit_to};

    pin_edge u_edge (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .pin(ccp_in[h]),
      .rise(rise),
      .fall(fall)
    );

    // Operating mode from the mode register
    always_comb begin
      op = OP_IDLE;
      if (!split) begin
        op = OP_IDLE;
      end else if (mode.mode == MODE_CAPTURE) begin
        op = mode.cmr ? OP_ETIME : OP_ECOUNT;
      end else if (mode.ams && !mode.cmr && mode.mode == MODE_PERIODIC) begin
        op = OP_PWM;
      end else if (mode.mode == MODE_ONESHOT ||
                   mode.mode == MODE_PERIODIC) begin
        op = OP_TIMER;
      end
    end

    // Counting step for the selected mode
    always_comb begin
      next_cnt = cnt;
      next_pcnt = pcnt;
      next_pwm = pwm_lvl;
      hw_stop = 1'b0;
      hit_to = 1'b0;
      hit_mt = 1'b0;
      hit_ce = 1'b0;
      if (run) begin
        case (op)
          OP_TIMER: begin
            if (pcnt != PRE_ZERO) begin
              next_pcnt = pcnt - PRE_ONE;
            end else if (at_zero) begin
              next_cnt = ilr;
              next_pcnt = pr;
              hit_to = 1'b1;
              hw_stop = (mode.mode == MODE_ONESHOT);
            end else begin
              next_cnt = cnt_dec;
              next_pcnt = pr;
            end
          end
          OP_PWM: begin
            next_cnt = at_zero ? ilr : cnt_dec;
            if (cnt == ilr) begin
              next_pwm = 1'b1;
            end else if (cnt == match) begin
              next_pwm = 1'b0;
            end
          end
          OP_ECOUNT: begin
            if (ev && cnt_dec == match) begin
              next_cnt = ilr;
              hit_mt = 1'b1;
              hw_stop = 1'b1;
            end else if (ev) begin
              next_cnt = cnt_dec;
            end
          end
          OP_ETIME: begin
            next_cnt = at_zero ? ilr : cnt_dec;
            hit_ce = ev;
          end
          default: begin
            next_cnt = cnt;
          end
        endcase
      end
    end

    // Interval write reloads the prescaler too, so the first step is full
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        cnt <= CNT_RESET;
        pcnt <= PRE_RESET;
        pwm_lvl <= 1'b0;
      end else if (clk_en) begin
        if (wr_ilr) begin
          cnt <= ilr_new;
          pcnt <= pr;
        end else begin
          cnt <= next_cnt;
          pcnt <= next_pcnt;
        end
        pwm_lvl <= (op == OP_PWM) ? next_pwm : 1'b0;
      end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        ilr <= CNT_RESET;
        match <= MATCH_RESET;
        pr <= PRE_RESET;
        mode <= '0;
      end else if (clk_en) begin
        if (wr_ilr) begin
          ilr <= ilr_new;
        end
        if (wr_match) begin
          match <= lanes16(match, wb_dat_i[15:0], wb_sel_i[1:0]);
        end
        if (wr_pr) begin
          pr <= wb_dat_i[7:0];
        end
        if (wr_mode && wb_sel_i[0]) begin
          mode <= half_mode_t'(wb_dat_i[3:0]);
        end
      end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        ctl <= '0;
        cap <= CNT_RESET;
        ris <= '0;
      end else if (clk_en) begin
        // Software write wins over the self-clear of the enable
        if (wr_ctl) begin
          ctl <= half_ctl_t'(ctl_wdata[h*HALF_STRIDE +: CTL_W]);
        end else if (hw_stop) begin
          ctl.en <= 1'b0;
        end
        if (hit_ce) begin
          cap <= cnt;
        end
        // Set beats clear so a flag raised during the clear survives
        ris <= (ris & ~icr_bits[h*HALF_STRIDE +: FLAG_W]) | flag_set;
      end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        adc_trig[h] <= 1'b0;
        ccp_out[h] <= 1'b0;
        ccp_oe[h] <= 1'b0;
      end else if (clk_en) begin
        adc_trig[h] <= hit_to & ctl.ote;
        ccp_out[h] <= (op == OP_PWM) & (next_pwm ^ ctl.pwml);
        ccp_oe[h] <= (op == OP_PWM);
      end
    end

    assign ctl_all[h*HALF_STRIDE +: HALF_STRIDE] = {2'b00, ctl};
    assign ris_all[h*HALF_STRIDE +: HALF_STRIDE] = {5'b00000, ris};
    assign mode_all[h] = mode;
    assign ilr_all[h] = ilr;
    assign match_all[h] = match;
    assign pr_all[h] = pr;
    assign val_all[h] = (op == OP_ETIME) ? cap : cnt;
  end

endmodule

// [rtl/timer_pkg.sv]
// Constants, register map and carrier types of the split 16-bit timer.
// Assumes a 32-bit classic Wishbone slave with byte addresses.
package timer_pkg;

  // ****************************************
  // Bus and register map
  // ****************************************
  localparam int ADR_W = 8;
  localparam logic [ADR_W-1:0] OFF_CFG = 8'h00;
  localparam logic [ADR_W-1:0] OFF_MODE [2] = '{8'h04, 8'h08};
  localparam logic [ADR_W-1:0] OFF_CTL = 8'h0c;
  localparam logic [ADR_W-1:0] OFF_IMR = 8'h18;
  localparam logic [ADR_W-1:0] OFF_RIS = 8'h1c;
  localparam logic [ADR_W-1:0] OFF_MIS = 8'h20;
  localparam logic [ADR_W-1:0] OFF_ICR = 8'h24;
  localparam logic [ADR_W-1:0] OFF_ILR [2] = '{8'h28, 8'h2c};
  localparam logic [ADR_W-1:0] OFF_MATCH [2] = '{8'h30, 8'h34};
  localparam logic [ADR_W-1:0] OFF_PRE [2] = '{8'h38, 8'h3c};
  localparam logic [ADR_W-1:0] OFF_VAL [2] = '{8'h48, 8'h4c};

  // ****************************************
  // Field layout and encodings
  // ****************************************
  localparam logic [2:0] CFG_SPLIT = 3'h4;
  localparam logic [1:0] MODE_ONESHOT = 2'h1;
  localparam logic [1:0] MODE_PERIODIC = 2'h2;
  localparam logic [1:0] MODE_CAPTURE = 2'h3;
  localparam logic [1:0] EV_RISE = 2'h0;
  localparam logic [1:0] EV_FALL = 2'h1;
  localparam logic [1:0] EV_BOTH = 2'h3;
  localparam int HALF_STRIDE = 8;
  localparam int CTL_W = 6;
  localparam int FLAG_W = 3;
  localparam int FLAG_TO = 0;
  localparam int FLAG_MATCH = 1;
  localparam int FLAG_CAP = 2;

  // ****************************************
  // Reset values and counter constants
  // ****************************************
  localparam logic [15:0] CNT_RESET = 16'hffff;
  localparam logic [15:0] MATCH_RESET = 16'h0000;
  localparam logic [7:0] PRE_RESET = 8'h00;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [7:0] PRE_ZERO = 8'h00;
  localparam logic [7:0] PRE_ONE = 8'h01;

  // ****************************************
  // Carrier types
  // ****************************************
  typedef struct packed {
    logic ams;
    logic cmr;
    logic [1:0] mode;
  } half_mode_t;

  typedef struct packed {
    logic pwml;
    logic ote;
    logic [1:0] event_sel;
    logic stall;
    logic en;
  } half_ctl_t;

  typedef enum logic [2:0] {
    OP_IDLE = 3'b000,
    OP_TIMER = 3'b001,
    OP_PWM = 3'b011,
    OP_ECOUNT = 3'b010,
    OP_ETIME = 3'b110
  } op_t;

endpackage

// [rtl/pin_edge.sv]
// Pin synchroniser and edge detector for one capture/compare input.
// Assumes the pin may change at any time relative to ref_clk.
`timescale 1ns/1ns
module pin_edge (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic pin,
  output logic rise,
  output logic fall
);

  // ****************************************
  // Two-flop synchroniser plus history
  // ****************************************
  logic meta;
  logic sync;
  logic prev;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= 1'b0;
      sync <= 1'b0;
      prev <= 1'b0;
    end else if (clk_en) begin
      meta <= pin;
      sync <= meta;
      prev <= sync;
    end
  end

  // Edges compare only settled samples, never the first flop
  assign rise = sync & ~prev;
  assign fall = ~sync & prev;

endmodule

// [bench/split_timer_chk.sv]
// Port checker for the split timer bus and pin outputs.
// Assumes clk_en high and a classic single-cycle bus master.
`timescale 1ns/1ns
module split_timer_chk
  import timer_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [1:0] ccp_out,
  input wire logic [1:0] ccp_oe,
  input wire logic [1:0] adc_trig
);
  // ****
  // Bus and pin properties
  // ****
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence req;
    wb_cyc_i && wb_stb_i && !wb_ack_o && clk_en;
  endsequence
  sequence rd_req;
    req ##0 !wb_we_i;
  endsequence
  chk_ack_after_req: assert property (req |=> wb_ack_o)
    else $error("no ack one cycle after request");
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  chk_dat_hold: assert property
    (!(wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o) |=> $stable(wb_dat_o))
    else $error("read data changed without read");
  chk_unmapped_zero: assert property
    (rd_req ##0 wb_adr_i[7:4] > 4'h4 |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  chk_clear_reads_zero: assert property
    (rd_req ##0 wb_adr_i == OFF_ICR |=> wb_dat_o == 32'h0)
    else $error("clear register read not zero");
  chk_trig_pulse: assert property
    (adc_trig[0] |=> !adc_trig[0] [*2])
    else $error("trigger not a single pulse");
  chk_pwm_drive: assert property ((ccp_out & ~ccp_oe) == 2'h0)
    else $error("pin level without output enable");
endmodule

bind split_timer split_timer_chk chk(.ref_clk, .rst_n, .clk_en, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .ccp_out, .ccp_oe,
  .adc_trig);

// [bench/ccp_source.sv]
// Edge source standing on the capture/compare pins.
// Assumes the caller waits for each task to return.
`timescale 1ns/1ns
module ccp_source (
  input wire logic ref_clk,
  output logic [1:0] lvl
);
  initial lvl = 2'h0;
  // Each level held four clocks, so edges stay at a quarter rate
  task automatic edges(input int i, input int n);
    repeat (n) begin
      @(posedge ref_clk);
      lvl[i] <= ~lvl[i];
      repeat (3) @(posedge ref_clk);
    end
  endtask
endmodule

// [bench/split_timer_tb.sv]
// Self-checking bench for the split timer over Wishbone.
// Assumes the checker is bound from its own file.
`timescale 1ns/1ns
module split_timer_tb
  import timer_pkg::*;
;
  logic ref_clk, rst_n, cyc, stb, we, halt, ack, irq, cen;
  logic [7:0] adr;
  logic [31:0] wdat, dat_o, rdat, q;
  logic [1:0] cout, coe, trig, src, pin;
  int n_errors, comparisons, n;
  // Pin level: the timer wins while it drives
  assign pin = (coe & cout) | (~coe & src);
  split_timer DUT(.ref_clk, .rst_n, .clk_en(cen), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .debug_halt(halt),
    .ccp_in(pin), .ccp_out(cout), .ccp_oe(coe), .adc_trig(trig),
    .timer_irq(irq));
  ccp_source model(.ref_clk, .lvl(src));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // ****
  // Tasks
  // ****
  task automatic check(input string what, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge ref_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (ack !== 1'b1 && k < 20);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (k >= 20) check("ack", 0, 1);
  endtask
  task automatic rd(input string w, input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    check(w, rdat, e);
  endtask
  task automatic hi(output int h);
    h = 0;
    repeat (20) begin
      @(posedge ref_clk);
      h += int'(cout[1]);
    end
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ****
  // Tests
  // ****
  initial begin
    rst_n = 1'b0;
    cen = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    wdat = 32'h0;
    halt = 1'b0;
    n_errors = 0;
    comparisons = 0;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd("ilr_a", OFF_ILR[0], 32'hffff);
    rd("val_a", OFF_VAL[0], 32'hffff);
    rd("pre_a", OFF_PRE[0], 32'h0);
    rd("icr", OFF_ICR, 32'h0);
    rd("unmapped", 8'h7c, 32'h0);
    $display("test reset done");
    wb(1, OFF_CFG, 32'h4);
    wb(1, OFF_MODE[0], 32'h1);
    wb(1, OFF_PRE[0], 32'h1);
    wb(1, OFF_ILR[0], 32'h5);
    wb(1, OFF_IMR, 32'h1);
    wb(1, OFF_CTL, 32'h11);
    n = 0;
    while (trig[0] !== 1'b1 && n < 60) begin
      @(posedge ref_clk);
      n++;
    end
    check("period", n >= 9 && n <= 16, 1);
    rd("ctl_a", OFF_CTL, 32'h10);
    rd("val_reload", OFF_VAL[0], 32'h5);
    rd("ris", OFF_RIS, 32'h1);
    rd("mis", OFF_MIS, 32'h1);
    check("irq", irq, 1);
    wb(1, OFF_ICR, 32'h707);
    rd("ris_clr", OFF_RIS, 32'h0);
    $display("test one_shot done");
    wb(1, OFF_MODE[1], 32'h2);
    wb(1, OFF_ILR[1], 32'h20);
    wb(1, OFF_CTL, 32'h300);
    halt <= 1'b1;
    wb(0, OFF_VAL[1], 32'h0);
    q = rdat;
    repeat (8) @(posedge ref_clk);
    rd("frozen", OFF_VAL[1], q);
    halt <= 1'b0;
    repeat (4) @(posedge ref_clk);
    wb(0, OFF_VAL[1], 32'h0);
    check("resumed", rdat != q, 1);
    wb(1, OFF_ILR[1], 32'h3);
    wb(0, OFF_VAL[1], 32'h0);
    check("new_load", rdat <= 32'h3, 1);
    n = 0;
    repeat (20) begin
      @(posedge ref_clk);
      n += int'(trig[1] !== 1'b0);
    end
    check("trig_off", n, 0);
    rd("ctl_b", OFF_CTL, 32'h300);
    rd("ris_b", OFF_RIS, 32'h100);
    rd("mis_b", OFF_MIS, 32'h0);
    wb(1, OFF_CTL, 32'h0);
    wb(1, OFF_ICR, 32'h707);
    $display("test periodic done");
    wb(1, OFF_MODE[0], 32'h3);
    wb(1, OFF_ILR[0], 32'ha);
    wb(1, OFF_MATCH[0], 32'h6);
    wb(1, OFF_IMR, 32'h2);
    wb(1, OFF_CTL, 32'hd);
    model.edges(0, 2);
    repeat (6) @(posedge ref_clk);
    rd("ec_step", OFF_VAL[0], 32'h8);
    model.edges(0, 4);
    repeat (8) @(posedge ref_clk);
    rd("ec_ris", OFF_RIS, 32'h2);
    check("ec_irq", irq, 1);
    rd("ec_ctl", OFF_CTL, 32'hc);
    rd("ec_val", OFF_VAL[0], 32'ha);
    wb(1, OFF_ICR, 32'h707);
    $display("test edge_count done");
    wb(1, OFF_MODE[0], 32'h7);
    wb(1, OFF_ILR[0], 32'hffff);
    wb(1, OFF_IMR, 32'h4);
    wb(1, OFF_CTL, 32'h1);
    repeat (10) @(posedge ref_clk);
    model.edges(0, 1);
    repeat (6) @(posedge ref_clk);
    wb(0, OFF_VAL[0], 32'h0);
    q = rdat;
    check("captured", q < 32'hffff, 1);
    rd("et_ris", OFF_RIS, 32'h4);
    repeat (20) @(posedge ref_clk);
    rd("held", OFF_VAL[0], q);
    model.edges(0, 2);
    repeat (6) @(posedge ref_clk);
    wb(0, OFF_VAL[0], 32'h0);
    check("later", rdat < q, 1);
    q = rdat;
    wb(1, OFF_CTL, 32'h5);
    model.edges(0, 1);
    repeat (6) @(posedge ref_clk);
    wb(0, OFF_VAL[0], 32'h0);
    check("fall_cap", rdat < q, 1);
    wb(1, OFF_CTL, 32'h0);
    wb(1, OFF_ICR, 32'h707);
    $display("test edge_time done");
    wb(1, OFF_MODE[1], 32'ha);
    wb(1, OFF_ILR[1], 32'h9);
    wb(1, OFF_MATCH[1], 32'h2);
    wb(1, OFF_IMR, 32'h707);
    wb(1, OFF_CTL, 32'h100);
    repeat (4) @(posedge ref_clk);
    hi(n);
    check("pwm_high", n, 14);
    check("pwm_oe", coe[1], 1);
    wb(1, OFF_CTL, 32'h2100);
    repeat (4) @(posedge ref_clk);
    hi(n);
    check("pwm_inv", n, 6);
    // Clock enable low must hold the pin where it stood
    cen <= 1'b0;
    @(posedge ref_clk);
    q = {31'h0, cout[1]};
    n = 0;
    repeat (20) begin
      @(posedge ref_clk);
      n += int'(cout[1] !== q[0]);
    end
    check("frozen_pin", n, 0);
    cen <= 1'b1;
    rd("pwm_ris", OFF_RIS, 32'h0);
    $display("test pwm done");
    tally_and_finish;
  end
  initial begin
    #100000;
    n_errors++;
    tally_and_finish;
  end
endmodule
